// file: rtl/kpa_pin_fsm.v
// Added by the designer: the register addresses and register access over APB.
`include "kpa_regs.vh"
`default_nettype none
module kpa_pin_fsm #(
  parameter [25:0] HOLD_CYC = `KPA_HOLD_CYC,
  parameter [25:0] BLINK_CYC = `KPA_BLINK_CYC,
  parameter [25:0] FAST_CYC = `KPA_FAST_CYC,
  parameter [25:0] FB_CYC = `KPA_FB_CYC
) (
  input wire mclk_in,
  input wire rst_n_in,
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [11:0] paddr_in,
  input wire [31:0] pwdata_in,
  output reg [31:0] prdata_out,
  output reg pready_out,
  output reg pslverr_out,
  input wire key_evt_in,
  input wire [3:0] key_code_in,
  input wire key_has_digit_in,
  input wire key_shift_in,
  input wire key_unlock_in,
  input wire shift_held_in,
  output reg led_red_out,
  output reg led_green_out,
  output reg led_blue_out,
  output reg unlocked_out
);
  // ---------------------------------------------------------------
  // States and feedback patterns
  // ---------------------------------------------------------------
  localparam [2:0] ST_STBY = 3'h0;
  localparam [2:0] ST_ADMIN = 3'h1;
  localparam [2:0] ST_ENT1 = 3'h2;
  localparam [2:0] ST_ENT2 = 3'h3;
  localparam [2:0] ST_LOGIN = 3'h4;
  localparam [2:0] ST_POL = 3'h5;
  localparam [2:0] ST_FB = 3'h6;
  localparam [2:0] ST_COPY = 3'h7;
  localparam [1:0] FB_GREEN = 2'h0;
  localparam [1:0] FB_BFAST = 2'h1;
  localparam [1:0] FB_GFAST = 2'h2;
  localparam [1:0] FB_RED = 2'h3;

  function [3:0] inc10;
    input [3:0] d;
    begin
      inc10 = (d == 4'h9) ? 4'h0 : d + 4'h1;
    end
  endfunction

  function [3:0] dec10;
    input [3:0] d;
    begin
      dec10 = (d == 4'h0) ? 4'h9 : d - 4'h1;
    end
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  reg [2:0] state_r;
  reg [2:0] fb_ret_r;
  reg [1:0] fb_pat_r;
  reg [25:0] fb_cnt_r;
  reg [25:0] hold_cnt_r;
  reg [25:0] blk_cnt_r;
  reg [25:0] fst_cnt_r;
  reg slow_r;
  reg fast_r;
  reg [6:0] idx_r;
  reg [6:0] len1_r;
  reg [6:0] adm_len_r;
  reg [6:0] usr_len_r;
  reg adm_set_r;
  reg usr_set_r;
  reg tgt_usr_r;
  reg login_usr_r;
  reg ovf_r;
  reg same_r;
  reg asc_r;
  reg desc_r;
  reg spec_r;
  reg match_r;
  reg [4:0] prev_r;
  reg [5:0] cp_r;
  reg [1:0] pcnt_r;
  reg [3:0] pd0_r;
  reg [3:0] pd1_r;
  reg [3:0] pd2_r;
  reg pbad_r;
  reg pol_act_r;
  reg pol_spec_r;
  reg [6:0] pol_len_r;
  reg kp_en_r;
  reg last_ok_r;
  reg last_bad_r;
  reg [4:0] buf_mem [0:63];
  reg [4:0] adm_mem [0:63];
  reg [4:0] usr_mem [0:63];

  // ---------------------------------------------------------------
  // Key decode and running PIN checks
  // ---------------------------------------------------------------
  wire key_go = key_evt_in & kp_en_r;
  wire is_dig = key_go & key_has_digit_in & ~key_unlock_in;
  wire is_cmd = key_go & key_has_digit_in & key_unlock_in & ~key_shift_in;
  wire is_term = key_go & ~key_has_digit_in & key_unlock_in & ~key_shift_in;
  wire is_shift = key_go & ~key_has_digit_in & key_shift_in &
                  ~key_unlock_in;
  // Shift travels as bit 4, so shift+1 never equals plain 1
  wire [4:0] sym = {key_shift_in, key_code_in};
  wire first = (idx_r == 7'h00);
  reg [4:0] ref_sym;
  always @* begin
    if (state_r == ST_ENT2)
      ref_sym = buf_mem[idx_r[5:0]];
    else if (login_usr_r)
      ref_sym = usr_mem[idx_r[5:0]];
    else
      ref_sym = adm_mem[idx_r[5:0]];
  end
  wire same_n = first | (same_r & (sym == prev_r));
  wire asc_n = ~key_shift_in & (first |
               (asc_r & (key_code_in == inc10(prev_r[3:0]))));
  wire desc_n = ~key_shift_in & (first |
                (desc_r & (key_code_in == dec10(prev_r[3:0]))));
  wire spec_n = (~first & spec_r) | key_shift_in;
  wire match_n = (first | match_r) & (sym == ref_sym);
  wire len_ok = ~ovf_r & (idx_r >= `KPA_PIN_MIN) &
                (idx_r <= `KPA_PIN_MAX);
  wire cplx_ok = len_ok & ~same_r & ~asc_r & ~desc_r;
  // Admin PIN skips policy terms entirely
  wire pol_ok = ~tgt_usr_r | ~pol_act_r |
                ((idx_r >= pol_len_r) & (~pol_spec_r | spec_r));
  wire [6:0] pol_len_n = ({3'h0, pd0_r} * 7'h0A) + {3'h0, pd1_r};
  wire pol_good = ~pbad_r & (pcnt_r == `KPA_POL_DIGITS) &
                  (pol_len_n >= `KPA_PIN_MIN) &
                  (pol_len_n <= `KPA_PIN_MAX) &
                  (pd2_r <= 4'h1);
  wire entering = (state_r == ST_ENT1) | (state_r == ST_ENT2) |
                  (state_r == ST_LOGIN);
  wire take_sym = is_dig & entering & ~idx_r[6];
  wire wr_buf = take_sym & (state_r == ST_ENT1);
  wire cp_on = (state_r == ST_COPY);
  wire acc = psel_in & penable_in & ~pready_out;
  // Writes land on the edge where the master sees pready
  wire done = psel_in & penable_in & pready_out;
  wire hit_ctrl = (paddr_in == `KPA_OFF_CTRL);
  wire hit_map = hit_ctrl | (paddr_in == `KPA_OFF_STATUS) |
                 (paddr_in == `KPA_OFF_POLICY) |
                 (paddr_in == `KPA_OFF_PINLEN);
  wire ctrl_wr = done & pwrite_in & hit_ctrl;
  wire lock_wr = ctrl_wr & pwdata_in[`KPA_CTRL_LOCK];
  // Status read clears the sticky result flags, except in the feedback or copy state
  wire clr_wr = acc & ~pwrite_in & (paddr_in == `KPA_OFF_STATUS);

  always @(posedge mclk_in) begin
    if (wr_buf)
      buf_mem[idx_r[5:0]] <= sym;
    if (cp_on & ~tgt_usr_r)
      adm_mem[cp_r] <= buf_mem[cp_r];
    if (cp_on & tgt_usr_r)
      usr_mem[cp_r] <= buf_mem[cp_r];
  end

  // ---------------------------------------------------------------
  // Blink time bases
  // ---------------------------------------------------------------
  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      blk_cnt_r <= 26'h0000000;
      fst_cnt_r <= 26'h0000000;
      slow_r <= 1'b0;
      fast_r <= 1'b0;
    end else begin
      if (blk_cnt_r == BLINK_CYC - 26'h0000001) begin
        blk_cnt_r <= 26'h0000000;
        slow_r <= ~slow_r;
      end else begin
        blk_cnt_r <= blk_cnt_r + 26'h0000001;
      end
      if (fst_cnt_r == FAST_CYC - 26'h0000001) begin
        fst_cnt_r <= 26'h0000000;
        fast_r <= ~fast_r;
      end else begin
        fst_cnt_r <= fst_cnt_r + 26'h0000001;
      end
    end
  end

  // ---------------------------------------------------------------
  // Command state machine
  // ---------------------------------------------------------------
  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= ST_STBY;
      fb_ret_r <= ST_STBY;
      fb_pat_r <= FB_RED;
      fb_cnt_r <= 26'h0000000;
      hold_cnt_r <= 26'h0000000;
      idx_r <= 7'h00;
      len1_r <= 7'h00;
      adm_len_r <= 7'h00;
      usr_len_r <= 7'h00;
      adm_set_r <= 1'b0;
      usr_set_r <= 1'b0;
      tgt_usr_r <= 1'b0;
      login_usr_r <= 1'b0;
      ovf_r <= 1'b0;
      same_r <= 1'b0;
      asc_r <= 1'b0;
      desc_r <= 1'b0;
      spec_r <= 1'b0;
      match_r <= 1'b0;
      prev_r <= 5'h00;
      cp_r <= 6'h00;
      pcnt_r <= 2'h0;
      pd0_r <= 4'h0;
      pd1_r <= 4'h0;
      pd2_r <= 4'h0;
      pbad_r <= 1'b0;
      pol_act_r <= 1'b0;
      pol_spec_r <= 1'b0;
      pol_len_r <= 7'h00;
      unlocked_out <= 1'b0;
      last_ok_r <= 1'b0;
      last_bad_r <= 1'b0;
    end else begin
      if (take_sym) begin
        idx_r <= idx_r + 7'h01;
        same_r <= same_n;
        asc_r <= asc_n;
        desc_r <= desc_n;
        spec_r <= spec_n;
        match_r <= match_n;
        prev_r <= sym;
      end else if (is_dig & entering) begin
        ovf_r <= 1'b1;
      end
      // Shift hold counts only in admin mode
      if ((state_r == ST_ADMIN) & shift_held_in)
        hold_cnt_r <= hold_cnt_r + 26'h0000001;
      else
        hold_cnt_r <= 26'h0000000;
      // Lock and clear come first: a same-cycle set or login wins
      if (lock_wr)
        unlocked_out <= 1'b0;
      if (clr_wr & ~((state_r == ST_FB) | (state_r == ST_COPY))) begin
        last_ok_r <= 1'b0;
        last_bad_r <= 1'b0;
      end
      case (state_r)
        ST_STBY: begin
          idx_r <= 7'h00;
          ovf_r <= 1'b0;
          if (is_cmd & (key_code_in == 4'h1)) begin
            // No admin PIN yet: first setup instead of login
            tgt_usr_r <= 1'b0;
            login_usr_r <= 1'b0;
            state_r <= adm_set_r ? ST_LOGIN : ST_ENT1;
          end else if (is_term & usr_set_r) begin
            login_usr_r <= 1'b1;
            state_r <= ST_LOGIN;
          end
        end
        ST_ADMIN: begin
          idx_r <= 7'h00;
          ovf_r <= 1'b0;
          pcnt_r <= 2'h0;
          pbad_r <= 1'b0;
          if (hold_cnt_r >= HOLD_CYC - 26'h0000001) begin
            state_r <= ST_STBY;
          end else if (is_cmd & (key_code_in == 4'h2)) begin
            tgt_usr_r <= 1'b0;
            state_r <= ST_ENT1;
          end else if (is_cmd & (key_code_in == 4'h3)) begin
            tgt_usr_r <= 1'b1;
            state_r <= ST_ENT1;
          end else if (is_cmd & (key_code_in == 4'h7)) begin
            state_r <= ST_POL;
          end
        end
        ST_ENT1: begin
          if (is_term) begin
            idx_r <= 7'h00;
            ovf_r <= 1'b0;
            state_r <= ST_FB;
            fb_cnt_r <= 26'h0000000;
            if (cplx_ok & pol_ok) begin
              len1_r <= idx_r;
              fb_pat_r <= FB_GREEN;
              fb_ret_r <= ST_ENT2;
            end else begin
              last_bad_r <= 1'b1;
              fb_pat_r <= FB_RED;
              fb_ret_r <= adm_set_r ? ST_ADMIN : ST_STBY;
            end
          end
        end
        ST_ENT2: begin
          if (is_term) begin
            fb_cnt_r <= 26'h0000000;
            if (~ovf_r & (idx_r == len1_r) & match_r) begin
              cp_r <= 6'h00;
              state_r <= ST_COPY;
            end else begin
              // Old PIN untouched; buffer is simply abandoned
              last_bad_r <= 1'b1;
              fb_pat_r <= FB_RED;
              fb_ret_r <= adm_set_r ? ST_ADMIN : ST_STBY;
              state_r <= ST_FB;
            end
          end
        end
        ST_COPY: begin
          cp_r <= cp_r + 6'h01;
          if (cp_r == 6'h3F) begin
            last_ok_r <= 1'b1;
            state_r <= ST_FB;
            fb_ret_r <= ST_ADMIN;
            if (tgt_usr_r) begin
              usr_len_r <= len1_r;
              usr_set_r <= 1'b1;
              fb_pat_r <= FB_GFAST;
            end else begin
              adm_len_r <= len1_r;
              adm_set_r <= 1'b1;
              fb_pat_r <= FB_BFAST;
            end
          end
        end
        ST_LOGIN: begin
          if (is_term) begin
            fb_cnt_r <= 26'h0000000;
            state_r <= ST_FB;
            fb_ret_r <= ST_STBY;
            fb_pat_r <= FB_RED;
            if (~ovf_r & match_r & (idx_r == (login_usr_r ?
                usr_len_r : adm_len_r))) begin
              last_ok_r <= 1'b1;
              if (login_usr_r) begin
                unlocked_out <= 1'b1;
                fb_pat_r <= FB_GREEN;
              end else begin
                state_r <= ST_ADMIN;
              end
            end else begin
              last_bad_r <= 1'b1;
            end
          end
        end
        ST_POL: begin
          if (is_dig) begin
            if (key_shift_in | (pcnt_r == `KPA_POL_DIGITS))
              pbad_r <= 1'b1;
            else
              pcnt_r <= pcnt_r + 2'h1;
            case (pcnt_r)
              2'h0: pd0_r <= key_code_in;
              2'h1: pd1_r <= key_code_in;
              2'h2: pd2_r <= key_code_in;
              default: pd2_r <= pd2_r;
            endcase
          end else if (is_shift) begin
            fb_cnt_r <= 26'h0000000;
            state_r <= ST_FB;
            fb_ret_r <= ST_ADMIN;
            if (pol_good) begin
              pol_act_r <= 1'b1;
              pol_len_r <= pol_len_n;
              pol_spec_r <= pd2_r[0];
              usr_set_r <= 1'b0;
              last_ok_r <= 1'b1;
              fb_pat_r <= FB_GREEN;
            end else begin
              last_bad_r <= 1'b1;
              fb_pat_r <= FB_RED;
            end
          end
        end
        ST_FB: begin
          fb_cnt_r <= fb_cnt_r + 26'h0000001;
          if (fb_cnt_r == FB_CYC - 26'h0000001)
            state_r <= fb_ret_r;
        end
        default: state_r <= ST_STBY;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // LEDs
  // ---------------------------------------------------------------
  reg red_n;
  reg grn_n;
  reg blu_n;
  always @* begin
    red_n = 1'b0;
    grn_n = 1'b0;
    blu_n = 1'b0;
    case (state_r)
      ST_STBY: begin
        red_n = ~unlocked_out;
        grn_n = unlocked_out;
      end
      ST_ADMIN: blu_n = 1'b1;
      ST_ENT1, ST_ENT2, ST_COPY: begin
        grn_n = slow_r;
        blu_n = 1'b1;
      end
      ST_LOGIN, ST_POL: begin
        grn_n = slow_r;
        blu_n = slow_r;
      end
      ST_FB: begin
        case (fb_pat_r)
          FB_GREEN: grn_n = 1'b1;
          FB_BFAST: blu_n = fast_r;
          FB_GFAST: grn_n = fast_r;
          default: red_n = 1'b1;
        endcase
      end
      default: red_n = 1'b1;
    endcase
  end

  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      led_red_out <= 1'b1;
      led_green_out <= 1'b0;
      led_blue_out <= 1'b0;
    end else begin
      led_red_out <= red_n;
      led_green_out <= grn_n;
      led_blue_out <= blu_n;
    end
  end

  // ---------------------------------------------------------------
  // APB slave: one wait state, every access
  // ---------------------------------------------------------------
  reg [31:0] rd_n;
  always @* begin
    rd_n = 32'h00000000;
    case (paddr_in)
      `KPA_OFF_CTRL: rd_n[`KPA_CTRL_KPEN] = kp_en_r;
      `KPA_OFF_STATUS: begin
        rd_n[`KPA_ST_STATE_LO +: 3] = state_r;
        rd_n[`KPA_ST_UNLOCKED] = unlocked_out;
        rd_n[`KPA_ST_ADMSET] = adm_set_r;
        rd_n[`KPA_ST_USRSET] = usr_set_r;
        rd_n[`KPA_ST_LASTOK] = last_ok_r;
        rd_n[`KPA_ST_LASTBAD] = last_bad_r;
      end
      `KPA_OFF_POLICY: begin
        rd_n[`KPA_POL_LEN_LO +: 7] = pol_len_r;
        rd_n[`KPA_POL_SPEC] = pol_spec_r;
        rd_n[`KPA_POL_ACT] = pol_act_r;
      end
      `KPA_OFF_PINLEN: begin
        rd_n[`KPA_LEN_ADM_LO +: 7] = adm_len_r;
        rd_n[`KPA_LEN_USR_LO +: 7] = usr_len_r;
      end
      default: rd_n = 32'h00000000;
    endcase
  end

  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h00000000;
      kp_en_r <= `KPA_RST_KPEN;
    end else begin
      pready_out <= acc;
      pslverr_out <= acc & ~hit_map;
      if (acc & ~pwrite_in)
        prdata_out <= rd_n;
      else
        prdata_out <= 32'h00000000;
      if (ctrl_wr)
        kp_en_r <= pwdata_in[`KPA_CTRL_KPEN];
    end
  end
endmodule
`default_nettype wire

// file: rtl/kpa_regs.vh
`ifndef KPA_REGS_VH
`define KPA_REGS_VH
// ---------------------------------------------------------------
// Register offsets (byte addresses)
// ---------------------------------------------------------------
`define KPA_OFF_CTRL 12'h000
`define KPA_OFF_STATUS 12'h004
`define KPA_OFF_POLICY 12'h008
`define KPA_OFF_PINLEN 12'h00C
// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define KPA_CTRL_KPEN 0
`define KPA_CTRL_LOCK 1
`define KPA_ST_STATE_LO 0
`define KPA_ST_UNLOCKED 4
`define KPA_ST_ADMSET 5
`define KPA_ST_USRSET 6
`define KPA_ST_LASTOK 7
`define KPA_ST_LASTBAD 8
`define KPA_POL_LEN_LO 0
`define KPA_POL_SPEC 8
`define KPA_POL_ACT 9
`define KPA_LEN_ADM_LO 0
`define KPA_LEN_USR_LO 8
// ---------------------------------------------------------------
// Reset values and limits
// ---------------------------------------------------------------
`define KPA_RST_KPEN 1'b1
`define KPA_PIN_MIN 7'h08
`define KPA_PIN_MAX 7'h40
`define KPA_POL_DIGITS 2'h3
// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define KPA_CLK_KHZ 40000
`define KPA_HOLD_MS 1000
`define KPA_BLINK_MS 250
`define KPA_FAST_MS 50
`define KPA_FB_MS 1000
`define KPA_HOLD_CYC (`KPA_HOLD_MS * `KPA_CLK_KHZ)
`define KPA_BLINK_CYC (`KPA_BLINK_MS * `KPA_CLK_KHZ)
`define KPA_FAST_CYC (`KPA_FAST_MS * `KPA_CLK_KHZ)
`define KPA_FB_CYC (`KPA_FB_MS * `KPA_CLK_KHZ)
`endif

// file: sim/kpa_pin_fsm_sva.sv
`default_nettype none
// ----------------------------------------
// Port checker
// ----------------------------------------
module kpa_pin_fsm_chk #(
  parameter [25:0] HOLD_CYC = 26'h0000014
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic key_evt_in,
  input wire logic [3:0] key_code_in,
  input wire logic key_has_digit_in,
  input wire logic key_shift_in,
  input wire logic key_unlock_in,
  input wire logic shift_held_in,
  input wire logic led_red_out,
  input wire logic led_green_out,
  input wire logic led_blue_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dc @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n_in);
  logic adm;
  logic cmd;
  logic dark;
  logic [25:0] hold_r;
  assign adm = led_blue_out & ~led_green_out & ~led_red_out;
  assign dark = ~led_blue_out & ~led_green_out & ~led_red_out;
  assign cmd = key_evt_in & key_unlock_in & key_has_digit_in & ~key_shift_in;
  // Shift hold time spent in admin mode
  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      hold_r <= 26'h0000000;
    else if (shift_held_in & adm)
      hold_r <= hold_r + 26'h0000001;
    else
      hold_r <= 26'h0000000;
  end
  AST_APB_ANSWER: assert property (psel_in & penable_in & ~pready_out
    |=> pready_out) else $error("pready late");
  AST_APB_PULSE: assert property (pready_out |=> !pready_out)
    else $error("pready longer than one cycle");
  AST_ERR_QUAL: assert property (pslverr_out |-> pready_out)
    else $error("pslverr without pready");
  AST_RDATA_IDLE: assert property (!pready_out |-> prdata_out == 32'h0)
    else $error("prdata not zero outside answer");
  AST_RESET_RED: assert property (
    $rose(rst_n_in) |-> led_red_out & ~led_green_out & ~led_blue_out)
    else $error("standby not red after reset");
  AST_EXIT_BOUND: assert property (
    hold_r <= HOLD_CYC + 26'h0000003) else $error("admin exit late");
  AST_CHANGE_START: assert property (
    cmd & key_code_in == 4'h2 & adm
    |-> ##3 (led_blue_out & ~led_red_out)[*4]) else $error("no change");
  AST_POLICY_START: assert property (
    cmd & key_code_in == 4'h7 & adm
    |-> ##3 (led_green_out == led_blue_out && !led_red_out)[*4])
    else $error("policy entry not shown");
  AST_POLICY_KEEP: assert property (
    key_evt_in & key_has_digit_in & ~key_unlock_in & ~key_shift_in & dark
    |-> ##3 (led_green_out == led_blue_out && !led_red_out)[*3])
    else $error("blink lost during digits");
  AST_COMMIT_FB: assert property (
    key_evt_in & key_shift_in & ~key_has_digit_in & ~key_unlock_in &
    led_green_out == led_blue_out & ~led_red_out
    |-> ##3 (!led_blue_out && (led_green_out ^ led_red_out))[*6])
    else $error("commit feedback wrong");
  COV_CHANGE: cover property (cmd & key_code_in == 4'h2 & adm);
  COV_POLICY: cover property (cmd & key_code_in == 4'h7 & adm);
  COV_EXIT: cover property (hold_r == HOLD_CYC);
endmodule
bind kpa_pin_fsm kpa_pin_fsm_chk #(.HOLD_CYC(HOLD_CYC)) u_chk (
  .mclk_in(mclk_in), .rst_n_in(rst_n_in), .psel_in(psel_in),
  .penable_in(penable_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out),
  .key_evt_in(key_evt_in), .key_code_in(key_code_in),
  .key_has_digit_in(key_has_digit_in), .key_shift_in(key_shift_in),
  .key_unlock_in(key_unlock_in), .shift_held_in(shift_held_in),
  .led_red_out(led_red_out), .led_green_out(led_green_out),
  .led_blue_out(led_blue_out));
`default_nettype wire

// file: sim/kpa_operator.sv
`default_nettype none
// ----------------------------------------
// Keypad operator
// ----------------------------------------
module kpa_operator (
  input wire logic mclk_in,
  output logic key_evt_out,
  output logic [3:0] key_code_out,
  output logic key_has_digit_out,
  output logic key_shift_out,
  output logic key_unlock_out,
  output logic shift_held_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    key_evt_out = 1'b0;
    key_code_out = 4'h0;
    key_has_digit_out = 1'b0;
    key_shift_out = 1'b0;
    key_unlock_out = 1'b0;
    shift_held_out = 1'b0;
  end
  // Fields inverted after release so stale values never look valid
  task automatic press(input logic sh, input logic un, input logic hd,
                       input logic [3:0] c);
    @(posedge mclk_in);
    key_evt_out <= 1'b1;
    key_shift_out <= sh;
    key_unlock_out <= un;
    key_has_digit_out <= hd;
    key_code_out <= c;
    @(posedge mclk_in);
    key_evt_out <= 1'b0;
    key_shift_out <= ~sh;
    key_unlock_out <= ~un;
    key_has_digit_out <= ~hd;
    key_code_out <= ~c;
    repeat (2) @(posedge mclk_in);
  endtask
  task automatic hold_shift(input int n);
    @(posedge mclk_in);
    shift_held_out <= 1'b1;
    repeat (n) @(posedge mclk_in);
    shift_held_out <= 1'b0;
  endtask
endmodule
`default_nettype wire

// file: sim/test_keypad_pin_admin_policy_fsm.sv
`default_nettype none
module test_keypad_pin_admin_policy_fsm;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [25:0] HOLD = 26'h0000014;
  logic mclk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic evt, hd, sh, un, held, red, grn, blu, unl;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, elen;
  logic [3:0] code;
  logic [64:0] q[$];
  int fail_count, checks, cyc, i;
  int seed = 2444;
  logic [39:0] c1 [7] = '{40'h2727968, 40'h33333333, 40'h78901234,
    40'h87654321, 40'h48213957, 40'h248613579, 40'h1111111111};
  logic [39:0] c2 [7] = '{40'h2727968, 40'h33333333, 40'h78901234,
    40'h87654321, 40'h48213958, 40'h248613579, 40'h1111111111};
  int cn [7] = '{7, 8, 8, 8, 8, 9, 10};
  logic [11:0] pd [7] = '{12'h120, 12'h070, 12'h650, 12'h092, 12'h640,
    12'h081, 12'h091};
  logic [9:0] pe [7] = '{10'h20C, 10'h20C, 10'h20C, 10'h20C, 10'h240,
    10'h308, 10'h309};
  kpa_pin_fsm #(.HOLD_CYC(HOLD), .BLINK_CYC(26'h0000004),
    .FAST_CYC(26'h0000002), .FB_CYC(26'h000000A)) u_kpa_pin_fsm (
    .mclk_in(mclk), .rst_n_in(rst_n), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .key_evt_in(evt), .key_code_in(code),
    .key_has_digit_in(hd), .key_shift_in(sh), .key_unlock_in(un),
    .shift_held_in(held), .led_red_out(red), .led_green_out(grn),
    .led_blue_out(blu), .unlocked_out(unl));
  kpa_operator u_kpa_operator (.mclk_in(mclk), .key_evt_out(evt),
    .key_code_out(code), .key_has_digit_out(hd), .key_shift_out(sh),
    .key_unlock_out(un), .shift_held_out(held));
  // ----------------------------------------
  // Checks and bus tasks
  // ----------------------------------------
  task automatic tally_and_finish;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cmp_reg(input logic [64:0] n);
    checks++;
    if ((prdata & n[63:32]) !== (n[31:0] & n[63:32]) ||
        pslverr !== n[64]) begin
      fail_count++;
      $display("Error prdata exp %h got %h err %b", n[31:0], prdata, pslverr);
    end
  endtask
  task automatic cmp_led(input logic [2:0] e);
    checks++;
    if ({red, grn, blu} !== e) begin
      fail_count++;
      $display("Error leds exp %b got %b", e, {red, grn, blu});
    end
  endtask
  task automatic cmp_unl(input logic e);
    checks++;
    if (unl !== e) begin
      fail_count++;
      $display("Error unlocked exp %b got %b", e, unl);
    end
  endtask
  // Read: d is the expected word under mask m; write: m is zero
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [31:0] m,
                     input logic e);
    q.push_back({e, m, d});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic pin(input logic [39:0] d, input logic [9:0] s, input int n);
    for (int k = n - 1; k >= 0; k--)
      u_kpa_operator.press(s[k], 1'b0, 1'b1, d[4*k +: 4]);
    u_kpa_operator.press(1'b0, 1'b1, 1'b0, 4'h0);
  endtask
  task automatic op(input logic [3:0] c);
    u_kpa_operator.press(1'b0, 1'b1, 1'b1, c);
  endtask
  task automatic dual(input logic [3:0] c, input logic [39:0] d,
                      input logic [9:0] s, input int n);
    op(c);
    pin(d, s, n);
    repeat (30) @(posedge mclk);
    pin(d, s, n);
    repeat (120) @(posedge mclk);
  endtask
  always @(posedge mclk) begin
    if (pready === 1'b1)
      cmp_reg(q.pop_front());
    cyc++;
    if (cyc == 30000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    cmp_led(3'b100);
    apb(1'b0, 12'h000, 32'h1, 32'h3, 1'b0);
    apb(1'b0, 12'h004, 32'h0, 32'h1F7, 1'b0);
    apb(1'b1, 12'h008, $random(seed), 32'h0, 1'b0);
    apb(1'b0, 12'h008, 32'h0, 32'h37F, 1'b0);
    apb(1'b0, 12'h010, 32'h0, 32'hFFFFFFFF, 1'b1);
    op(4'h7);
    repeat (6) @(posedge mclk);
    cmp_led(3'b100);
    op(4'h1);
    pin(40'h72779673, 10'h000, 8);
    repeat (30) @(posedge mclk);
    pin(40'h72779673, 10'h000, 8);
    repeat (120) @(posedge mclk);
    apb(1'b0, 12'h00C, 32'h8, 32'h7F, 1'b0);
    apb(1'b1, 12'h000, 32'h3, 32'h0, 1'b0);
    op(4'h1);
    pin(40'h72779673, 10'h000, 8);
    repeat (40) @(posedge mclk);
    apb(1'b0, 12'h004, 32'h21, 32'h27, 1'b0);
    cmp_led(3'b001);
    dual(4'h3, 40'h248813579, 10'h101, 9);
    apb(1'b0, 12'h004, 32'hE1, 32'h1E7, 1'b0);
    for (i = 0; i < 7; i++) begin
      op(4'h7);
      for (int k = 2; k >= 0; k--)
        u_kpa_operator.press(1'b0, 1'b0, 1'b1, pd[i][4*k +: 4]);
      u_kpa_operator.press(1'b1, 1'b0, 1'b0, 4'h0);
      repeat (30) @(posedge mclk);
      apb(1'b0, 12'h008, {22'h0, pe[i]},
          32'h37F, 1'b0);
    end
    apb(1'b0, 12'h004, 32'h1A1, 32'h1E7, 1'b0);
    elen = 32'h8;
    for (i = 0; i < 7; i++) begin
      op(4'h2);
      pin(c1[i], (i == 6) ? 10'h020 : 10'h000, cn[i]);
      @(posedge mclk);
      if (i > 4)
        cmp_led(3'b010);
      repeat (30) @(posedge mclk);
      pin(c2[i], (i == 6) ? 10'h020 : 10'h000, cn[i]);
      repeat (120) @(posedge mclk);
      if (i > 4)
        elen = cn[i];
      apb(1'b0, 12'h004, (i > 4) ? 32'hA1 : 32'h121,
          32'h1A7, 1'b0);
      apb(1'b0, 12'h00C, elen, 32'h7F, 1'b0);
    end
    dual(4'h3, 40'h248813579, 10'h000, 9);
    apb(1'b0, 12'h004, 32'h121, 32'h1E7, 1'b0);
    dual(4'h3, 40'h248813579, 10'h101, 9);
    apb(1'b0, 12'h00C, 32'h90A, 32'h7F7F, 1'b0);
    u_kpa_operator.hold_shift(HOLD + 10);
    repeat (3) @(posedge mclk);
    cmp_led(3'b100);
    apb(1'b0, 12'h004, 32'h0, 32'h7, 1'b0);
    for (i = 0; i < 2; i++) begin
      u_kpa_operator.press(1'b0, 1'b1, 1'b0, 4'h0);
      pin(40'h248813579, i ? 10'h101 : 10'h102, 9);
      repeat (30) @(posedge mclk);
      apb(1'b0, 12'h004, i ? 32'h90 : 32'h100, 32'h197, 1'b0);
    end
    cmp_unl(1'b1);
    cmp_led(3'b010);
    tally_and_finish();
  end
endmodule
`default_nettype wire
